// file: uac_defs.vh
`ifndef UAC_DEFS_VH
`define UAC_DEFS_VH

// ****************************************
// Register map
// ****************************************
`define UAC_ADDR_TX_BURST 6'h00
`define UAC_ADDR_RX_EVENT 6'h01
`define UAC_ADDR_MEAS_SEL 6'h02
`define UAC_ADDR_TEMP_THR 6'h03
`define UAC_RST_TX_BURST 8'h45
`define UAC_RST_RX_EVENT 8'h40
`define UAC_RST_MEAS_SEL 8'h00
`define UAC_RST_TEMP_THR 8'h03
`define UAC_RST_TXDIV 3'h2
`define UAC_RST_BURST 5'h05
`define UAC_RST_THR 3'h3
`define UAC_RST_THR_MV 11'h07D
`define UAC_READ_ZERO 8'h00

// ****************************************
// Field positions
// ****************************************
`define UAC_TXDIV_HI 7
`define UAC_TXDIV_LO 5
`define UAC_BURST_HI 4
`define UAC_BURST_LO 0
`define UAC_NRX_HI 2
`define UAC_NRX_LO 0
`define UAC_CM_BIT 7
`define UAC_MT_BIT 6
`define UAC_DAMP_BIT 5
`define UAC_TCH_BIT 6
`define UAC_RTD_BIT 5
`define UAC_TCLK_BIT 4
`define UAC_BLANK_BIT 3
`define UAC_THR_HI 2
`define UAC_THR_LO 0

// ****************************************
// Command byte and decoded constants
// ****************************************
`define UAC_CMD_WR_BIT 6
`define UAC_CMD_ADDR_HI 5
`define UAC_CMD_ADDR_LO 0
`define UAC_BITS_CMD 5'h08
`define UAC_BITS_ALL 5'h10
`define UAC_DIV_TWO 9'h002
`define UAC_TEMP_FIXED_DIV 9'h008
`define UAC_STOPS_NOCOUNT 6'h20
`define UAC_NRX_NOCOUNT 3'h0

`endif

// file: uac_config_regs.v
`timescale 1ns/100ps
`include "uac_defs.vh"

module uac_config_regs (
  input wire clock,
  input wire rst,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_sdi,
  output wire spi_sdo,
  output wire spi_sdo_oe_n,
  input wire meas_start,
  input wire stop_event,
  input wire listen_expired,
  input wire error_clear,
  input wire [9:0] wait_time,
  output reg [2:0] tx_clock_divider,
  output reg [8:0] tx_divide_ratio,
  output reg [4:0] burst_pulse_count,
  output reg [5:0] stop_pulse_target,
  output reg event_count_enable,
  output reg common_mode_source,
  output reg measurement_type,
  output reg damping_enable,
  output reg temp_channel_select,
  output reg sensor_type_select,
  output reg [8:0] temp_divide_ratio,
  output reg blanking_enable,
  output reg [9:0] blanking_length,
  output reg [2:0] echo_threshold_code,
  output reg [10:0] echo_threshold_mv,
  output reg timeout_flag,
  output reg error_out_n
);

  // ****************************************
  // Serial port
  // ****************************************
  reg [7:0] tx_burst_config_q;
  reg [7:0] rx_event_config_q;
  reg [7:0] measurement_select_config_q;
  reg [7:0] temp_and_threshold_config_q;
  reg sclk_q;
  reg [4:0] bit_cnt_q;
  reg [7:0] rx_shift_q;
  reg [7:0] cmd_q;
  reg [7:0] tx_shift_q;
  reg [7:0] rd_data;
  wire sclk_rise;
  wire sclk_fall;
  wire [7:0] rx_next;
  wire cmd_write;
  wire [5:0] cmd_addr;
  wire write_done;

  assign sclk_rise = spi_sclk & ~sclk_q;
  assign sclk_fall = ~spi_sclk & sclk_q;
  assign rx_next = {rx_shift_q[6:0], spi_sdi};
  assign cmd_write = cmd_q[`UAC_CMD_WR_BIT];
  assign cmd_addr = cmd_q[`UAC_CMD_ADDR_HI:`UAC_CMD_ADDR_LO];
  assign write_done = ~spi_cs_n & sclk_rise & cmd_write & (bit_cnt_q == `UAC_BITS_ALL - 5'h01);
  assign spi_sdo = tx_shift_q[7];
  assign spi_sdo_oe_n = spi_cs_n | cmd_write | (bit_cnt_q < `UAC_BITS_CMD);

  always @* begin
    case (cmd_addr)
      `UAC_ADDR_TX_BURST: rd_data = tx_burst_config_q;
      `UAC_ADDR_RX_EVENT: rd_data = rx_event_config_q;
      `UAC_ADDR_MEAS_SEL: rd_data = measurement_select_config_q;
      `UAC_ADDR_TEMP_THR: rd_data = temp_and_threshold_config_q;
      default: rd_data = `UAC_READ_ZERO;
    endcase
  end

  // Chip select high aborts any frame, so the next frame always starts clean.
  always @(posedge clock) begin
    if (rst) begin
      sclk_q <= 1'b0;
      bit_cnt_q <= 5'h00;
      rx_shift_q <= 8'h00;
      cmd_q <= 8'h00;
      tx_shift_q <= 8'h00;
    end else begin
      sclk_q <= spi_sclk;
      if (spi_cs_n) begin
        bit_cnt_q <= 5'h00;
        cmd_q <= 8'h00;
      end else begin
        if (sclk_rise && bit_cnt_q < `UAC_BITS_ALL) begin
          rx_shift_q <= rx_next;
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == `UAC_BITS_CMD - 5'h01) begin
            cmd_q <= rx_next;
          end
        end
        if (sclk_fall) begin
          if (bit_cnt_q == `UAC_BITS_CMD) begin
            tx_shift_q <= rd_data;
          end else begin
            tx_shift_q <= {tx_shift_q[6:0], 1'b0};
          end
        end
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Reserved bits are stored as written; the host keeps them at their reset values.
  always @(posedge clock) begin
    if (rst) begin
      tx_burst_config_q <= `UAC_RST_TX_BURST;
      rx_event_config_q <= `UAC_RST_RX_EVENT;
      measurement_select_config_q <= `UAC_RST_MEAS_SEL;
      temp_and_threshold_config_q <= `UAC_RST_TEMP_THR;
    end else if (write_done) begin
      case (cmd_addr)
        `UAC_ADDR_TX_BURST: tx_burst_config_q <= rx_next;
        `UAC_ADDR_RX_EVENT: rx_event_config_q <= rx_next;
        `UAC_ADDR_MEAS_SEL: measurement_select_config_q <= rx_next;
        `UAC_ADDR_TEMP_THR: temp_and_threshold_config_q <= rx_next;
        default: tx_burst_config_q <= tx_burst_config_q;
      endcase
    end
  end

  // ****************************************
  // Decoded controls
  // ****************************************
  wire [2:0] div_code;
  wire [2:0] nrx_code;
  wire [2:0] thr_code;
  reg [10:0] thr_mv;
  assign div_code = tx_burst_config_q[`UAC_TXDIV_HI:`UAC_TXDIV_LO];
  assign nrx_code = rx_event_config_q[`UAC_NRX_HI:`UAC_NRX_LO];
  assign thr_code = temp_and_threshold_config_q[`UAC_THR_HI:`UAC_THR_LO];

  always @* begin
    case (thr_code)
      3'h0: thr_mv = 11'h023;
      3'h1: thr_mv = 11'h032;
      3'h2: thr_mv = 11'h04B;
      3'h3: thr_mv = 11'h07D;
      3'h4: thr_mv = 11'h0DC;
      3'h5: thr_mv = 11'h19A;
      3'h6: thr_mv = 11'h307;
      default: thr_mv = 11'h5DC;
    endcase
  end

  // Outputs are snapshots taken at measurement start, so a write in the middle
  // of a burst never changes the running measurement.
  always @(posedge clock) begin
    if (rst) begin
      tx_clock_divider <= `UAC_RST_TXDIV;
      tx_divide_ratio <= `UAC_TEMP_FIXED_DIV;
      burst_pulse_count <= `UAC_RST_BURST;
      stop_pulse_target <= `UAC_STOPS_NOCOUNT;
      event_count_enable <= 1'b0;
      common_mode_source <= 1'b0;
      measurement_type <= 1'b0;
      damping_enable <= 1'b0;
      temp_channel_select <= 1'b0;
      sensor_type_select <= 1'b0;
      temp_divide_ratio <= `UAC_TEMP_FIXED_DIV;
      blanking_enable <= 1'b0;
      blanking_length <= 10'h000;
      echo_threshold_code <= `UAC_RST_THR;
      echo_threshold_mv <= `UAC_RST_THR_MV;
    end else if (meas_start) begin
      tx_clock_divider <= div_code;
      // Shifting a constant two avoids a three-bit code plus one, which wraps to zero for code 7.
      tx_divide_ratio <= `UAC_DIV_TWO << div_code;
      burst_pulse_count <= tx_burst_config_q[`UAC_BURST_HI:`UAC_BURST_LO];
      stop_pulse_target <= (nrx_code == `UAC_NRX_NOCOUNT) ? `UAC_STOPS_NOCOUNT : {3'h0, nrx_code};
      event_count_enable <= (nrx_code != `UAC_NRX_NOCOUNT);
      common_mode_source <= measurement_select_config_q[`UAC_CM_BIT];
      measurement_type <= measurement_select_config_q[`UAC_MT_BIT];
      damping_enable <= measurement_select_config_q[`UAC_DAMP_BIT];
      temp_channel_select <= temp_and_threshold_config_q[`UAC_TCH_BIT];
      sensor_type_select <= temp_and_threshold_config_q[`UAC_RTD_BIT];
      temp_divide_ratio <= temp_and_threshold_config_q[`UAC_TCLK_BIT] ?
        (`UAC_DIV_TWO << div_code) : `UAC_TEMP_FIXED_DIV;
      blanking_enable <= temp_and_threshold_config_q[`UAC_BLANK_BIT] &
        ~measurement_select_config_q[`UAC_MT_BIT];
      blanking_length <= wait_time;
      echo_threshold_code <= thr_code;
      echo_threshold_mv <= thr_mv;
    end
  end

  // ****************************************
  // Listening timeout
  // ****************************************
  reg listening_q;
  reg [5:0] stop_cnt_q;
  always @(posedge clock) begin
    if (rst) begin
      listening_q <= 1'b0;
      stop_cnt_q <= 6'h00;
      timeout_flag <= 1'b0;
      error_out_n <= 1'b1;
    end else begin
      if (meas_start) begin
        listening_q <= 1'b1;
        stop_cnt_q <= 6'h00;
      end else if (listening_q) begin
        if (stop_event) begin
          stop_cnt_q <= stop_cnt_q + 6'h01;
          if (stop_cnt_q + 6'h01 == stop_pulse_target) begin
            listening_q <= 1'b0;
          end
        end else if (listen_expired) begin
          listening_q <= 1'b0;
        end
      end
      // A timeout in the same cycle as a clear still sets the error.
      if (listening_q && !meas_start && !stop_event && listen_expired && stop_cnt_q < stop_pulse_target) begin
        timeout_flag <= 1'b1;
        error_out_n <= 1'b0;
      end else if (error_clear) begin
        timeout_flag <= 1'b0;
        error_out_n <= 1'b1;
      end
    end
  end

endmodule // uac_config_regs

// file: uac_config_regs_sva.sv
`timescale 1ns/100ps
module uac_chk (
  input wire clock,
  input wire rst,
  input wire meas_start,
  input wire listen_expired,
  input wire error_clear,
  input wire spi_cs_n,
  input wire spi_sdo_oe_n,
  input wire [2:0] tx_clock_divider,
  input wire [8:0] tx_divide_ratio,
  input wire [4:0] burst_pulse_count,
  input wire [5:0] stop_pulse_target,
  input wire event_count_enable,
  input wire measurement_type,
  input wire [8:0] temp_divide_ratio,
  input wire blanking_enable,
  input wire [2:0] echo_threshold_code,
  input wire [10:0] echo_threshold_mv,
  input wire timeout_flag,
  input wire error_out_n
);
  localparam logic [10:0] MV [8] = '{11'h023, 11'h032, 11'h04B, 11'h07D, 11'h0DC, 11'h19A, 11'h307, 11'h5DC};
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // A clear always wins when no expiry arrives in the same cycle.
  sequence s_clr;
    error_clear && !listen_expired;
  endsequence
  AST_RATIO: assert property (tx_divide_ratio == (9'h002 << tx_clock_divider))
    else $error("divide ratio wrong");
  AST_TARGET: assert property (event_count_enable == (stop_pulse_target != 6'h20))
    else $error("event target wrong");
  AST_TDIV: assert property (temp_divide_ratio == 9'h008 || temp_divide_ratio == tx_divide_ratio)
    else $error("temperature divider wrong");
  AST_BLANK: assert property (blanking_enable |-> !measurement_type)
    else $error("blanking in temperature mode");
  AST_MV: assert property (echo_threshold_mv == MV[echo_threshold_code])
    else $error("threshold level wrong");
  AST_HOLD: assert property (!meas_start |=> $stable(tx_divide_ratio) && $stable(burst_pulse_count))
    else $error("output moved without start");
  AST_TO: assert property ($rose(timeout_flag) |-> $past(listen_expired))
    else $error("timeout without expiry");
  AST_ERRN: assert property (error_out_n == !timeout_flag)
    else $error("error pin disagrees");
  AST_CLR: assert property (s_clr |=> !timeout_flag)
    else $error("clear ignored");
  AST_OE: assert property (spi_cs_n |-> spi_sdo_oe_n)
    else $error("output driven while deselected");
endmodule // uac_chk
bind uac_config_regs uac_chk i_uac_chk (.clock, .rst, .meas_start, .listen_expired, .error_clear, .spi_cs_n,
  .spi_sdo_oe_n, .tx_clock_divider, .tx_divide_ratio, .burst_pulse_count, .stop_pulse_target,
  .event_count_enable, .measurement_type, .temp_divide_ratio, .blanking_enable, .echo_threshold_code,
  .echo_threshold_mv, .timeout_flag, .error_out_n);

// file: uac_spi_host.sv
`timescale 1ns/100ps
module uac_spi_host (
  input wire clock,
  output logic spi_sclk = 1'b0,
  output logic spi_cs_n = 1'b1,
  output logic spi_sdi = 1'b1,
  input wire spi_sdo,
  input wire spi_sdo_oe_n
);
  // Three clocks per phase keeps the sampled clock well clear of the two-cycle minimum.
  task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
    @(negedge clock) spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = frame[i];
      repeat (3) @(negedge clock);
      spi_sclk = 1'b1;
      if (i < 8) rd[i] = spi_sdo_oe_n ? 1'bx : spi_sdo;
      repeat (3) @(negedge clock);
      spi_sclk = 1'b0;
    end
    repeat (3) @(negedge clock);
    spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;
  endtask
endmodule // uac_spi_host

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic meas_start = 1'b0;
  logic stop_event = 1'b0;
  logic listen_expired = 1'b0;
  logic error_clear = 1'b0;
  logic [9:0] wait_time = 10'h2A5;
  logic [7:0] rd;
  int err_count = 0;
  int comparisons = 0;
  wire spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n;
  wire [2:0] tx_clock_divider, echo_threshold_code;
  wire [8:0] tx_divide_ratio, temp_divide_ratio;
  wire [4:0] burst_pulse_count;
  wire [5:0] stop_pulse_target;
  wire [9:0] blanking_length;
  wire [10:0] echo_threshold_mv;
  wire event_count_enable, common_mode_source, measurement_type, damping_enable, temp_channel_select;
  wire sensor_type_select, blanking_enable, timeout_flag, error_out_n;
  always #2 clock = ~clock;
  uac_config_regs i_uac_config_regs (.clock, .rst, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe_n,
    .meas_start, .stop_event, .listen_expired, .error_clear, .wait_time, .tx_clock_divider, .tx_divide_ratio,
    .burst_pulse_count, .stop_pulse_target, .event_count_enable, .common_mode_source, .measurement_type,
    .damping_enable, .temp_channel_select, .sensor_type_select, .temp_divide_ratio, .blanking_enable,
    .blanking_length, .echo_threshold_code, .echo_threshold_mv, .timeout_flag, .error_out_n);
  uac_spi_host i_uac_spi_host (.clock, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe_n);
  // ********
  // Helpers
  // ********
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_uac_spi_host.xfer({2'b01, a, d}, rd);
    repeat (2) @(negedge clock);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    i_uac_spi_host.xfer({2'b00, a, 8'h00}, rd);
    chk("read", exp, rd);
  endtask
  task automatic start;
    meas_start = 1'b1;
    @(negedge clock) meas_start = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_reset;
    rdchk(6'h00, 8'h45);
    rdchk(6'h01, 8'h40);
    rdchk(6'h02, 8'h00);
    rdchk(6'h03, 8'h03);
    rdchk(6'h09, 8'h00);
    start;
    chk("ratio", 9'h008, tx_divide_ratio);
    chk("burst", 5'h05, burst_pulse_count);
    chk("target", 6'h20, stop_pulse_target);
    chk("mv", 11'h07D, echo_threshold_mv);
    chk("divider", 3'h2, tx_clock_divider);
    chk("count_en", 1'h0, event_count_enable);
    chk("thr", 3'h3, echo_threshold_code);
  endtask
  task automatic t_fields;
    wr(6'h00, 8'hFF);
    wr(6'h01, 8'h47);
    wr(6'h02, 8'hE0);
    wr(6'h03, 8'h7F);
    rdchk(6'h03, 8'h7F);
    start;
    chk("ratio", 9'h100, tx_divide_ratio);
    chk("burst", 5'h1F, burst_pulse_count);
    chk("target", 6'h07, stop_pulse_target);
    chk("modes", 3'h7, {common_mode_source, measurement_type, damping_enable});
    chk("temp", 2'h3, {temp_channel_select, sensor_type_select});
    chk("tdiv", 9'h100, temp_divide_ratio);
    chk("blank", 1'h0, blanking_enable);
    chk("mv", 11'h5DC, echo_threshold_mv);
    chk("divider", 3'h7, tx_clock_divider);
    chk("count_en", 1'h1, event_count_enable);
    chk("thr", 3'h7, echo_threshold_code);
  endtask
  task automatic t_tof;
    wr(6'h00, 8'h00);
    wr(6'h01, 8'h42);
    wr(6'h02, 8'h00);
    wr(6'h03, 8'h08);
    chk("held", 9'h100, tx_divide_ratio);
    start;
    chk("blank", 1'h1, blanking_enable);
    chk("blen", 10'h2A5, blanking_length);
    chk("tdiv", 9'h008, temp_divide_ratio);
    chk("mv", 11'h023, echo_threshold_mv);
    chk("ratio", 9'h002, tx_divide_ratio);
    stop_event = 1'b1;
    @(negedge clock) stop_event = 1'b0;
    listen_expired = 1'b1;
    @(negedge clock) listen_expired = 1'b0;
    @(negedge clock);
    chk("timeout", 2'h2, {timeout_flag, error_out_n});
    error_clear = 1'b1;
    @(negedge clock) error_clear = 1'b0;
    @(negedge clock);
    chk("cleared", 2'h1, {timeout_flag, error_out_n});
  endtask
  task automatic t_events;
    start;
    stop_event = 1'b1;
    repeat (2) @(negedge clock);
    stop_event = 1'b0;
    listen_expired = 1'b1;
    @(negedge clock) listen_expired = 1'b0;
    @(negedge clock);
    chk("target met", 2'h1, {timeout_flag, error_out_n});
    start;
    listen_expired = 1'b1;
    error_clear = 1'b1;
    @(negedge clock) listen_expired = 1'b0;
    error_clear = 1'b0;
    @(negedge clock);
    chk("set wins", 2'h2, {timeout_flag, error_out_n});
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    chk("reset err", 2'h1, {timeout_flag, error_out_n});
    rdchk(6'h00, 8'h45);
    rdchk(6'h01, 8'h40);
    start;
    chk("ratio", 9'h008, tx_divide_ratio);
  endtask
  task automatic complete_run;
    $display("Checks %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // A run of about sixteen accesses takes near 6.6 us, so the limit leaves ample margin.
  initial begin
    #50000;
    err_count++;
    complete_run;
  end
  initial begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    t_reset;
    t_fields;
    t_tof;
    t_events;
    complete_run;
  end
endmodule // tb_top
